// >>> include/tlim_defines.svh
/*
 * Constants of the torque-limit input mapper: bus offsets, field
 * positions, reset values and selector code points.
 * Assumes it is included by bare name from include/.
 */
`ifndef TLIM_DEFINES_SVH
`define TLIM_DEFINES_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define TLIM_ADR_SELECT     8'h00
`define TLIM_ADR_OUTSEL     8'h04
`define TLIM_ADR_CONTROL    8'h08
`define TLIM_ADR_STATUS     8'h0c
`define TLIM_ADR_ACTIVE     8'h10

// ****************************************************************
// field positions
// ****************************************************************
`define TLIM_SEL_FWD_LSB    0
`define TLIM_SEL_REV_LSB    4
`define TLIM_CTRL_RESTART   0
`define TLIM_STAT_FWD       0
`define TLIM_STAT_REV       1
`define TLIM_STAT_PEND      2
`define TLIM_STAT_ERR       3
`define TLIM_STAT_TERM_LSB  4
`define TLIM_ACT_FWD_LSB    0
`define TLIM_ACT_REV_LSB    4
`define TLIM_ACT_OUT_LSB    16

// ****************************************************************
// reset values and the output-select digit limit
// ****************************************************************
`define TLIM_RST_CODE       4'h8
`define TLIM_RST_OUTSEL     16'h0000
`define TLIM_PIN_IDLE       1'b1
`define TLIM_DIGIT_MAX      4'h3

// ****************************************************************
// selector code points
// ****************************************************************
`define TLIM_CODE_A_ON      4'h0
`define TLIM_CODE_B_ON      4'h1
`define TLIM_CODE_C_ON_LO   4'h2
`define TLIM_CODE_C_ON_HI   4'h6
`define TLIM_CODE_FORCE_ON  4'h7
`define TLIM_CODE_FORCE_OFF 4'h8
`define TLIM_CODE_A_OFF     4'h9
`define TLIM_CODE_B_OFF     4'ha

`endif

// >>> include/tlim_pkg.sv
/*
 * Types of the torque-limit input mapper.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none

package tlim_pkg;

    typedef logic [3:0]  tlim_code_t;
    typedef logic [15:0] tlim_outsel_t;
    typedef logic [31:0] tlim_word_t;
    typedef logic [7:0]  tlim_adr_t;
    typedef logic [3:0]  tlim_sel_t;
    typedef logic [2:0]  tlim_term_t;

    typedef enum logic [2:0]
    {
        TLIM_SRC_A   = 3'h0,
        TLIM_SRC_B   = 3'h1,
        TLIM_SRC_C   = 3'h3,
        TLIM_SRC_ON  = 3'h2,
        TLIM_SRC_OFF = 3'h6
    } tlim_src_t;

endpackage : tlim_pkg

`default_nettype wire

// >>> tb/tlim_host_model.sv
/*
 * Host equipment driving the three terminals.
 * Assumes the bench asks for levels; bit 0 is terminal a.
 */
`default_nettype none

module tlim_host_model
(
    // clock
    input wire logic       mclk,
    // levels asked for
    input wire logic [2:0] level_req,
    // terminals, low means on
    output logic           input_terminal_a,
    output logic           input_terminal_b,
    output logic           input_terminal_c
);
    timeunit 1ns;
    timeprecision 1ns;

    // idle high so every terminal starts off
    logic [2:0] lvl = 3'h7;

    always @(posedge mclk)
    begin
        lvl <= level_req;
    end

    assign input_terminal_a = lvl[0];
    assign input_terminal_b = lvl[1];
    assign input_terminal_c = lvl[2];

endmodule : tlim_host_model

`default_nettype wire

// >>> tb/tlim_mapper_checker.sv
/*
 * Port checker for the torque-limit input mapper.
 * Assumes it is bound onto tlim_mapper, one clock mclk.
 */
`default_nettype none

module tlim_mapper_checker
(
    // clock and reset
    input wire logic                 mclk,
    input wire logic                 reset,
    // bus
    input wire logic                 wb_cyc_i,
    input wire logic                 wb_stb_i,
    input wire logic                 wb_we_i,
    input wire tlim_pkg::tlim_adr_t  wb_adr_i,
    input wire logic                 wb_ack_o,
    // pins and results
    input wire logic                 input_terminal_a,
    input wire logic                 input_terminal_b,
    input wire logic                 input_terminal_c,
    input wire logic                 fwd_torque_limit_req,
    input wire logic                 rev_torque_limit_req,
    input wire tlim_pkg::tlim_outsel_t output_signal_sel
);
    timeunit 1ns;
    timeprecision 1ns;
    import tlim_pkg::*;

    // ****************************************************************
    // helper ages
    // ****************************************************************
    logic       take;
    logic       ctl_wr;
    logic [2:0] pins_d;
    logic [7:0] ctl_age;
    logic [7:0] pin_age;

    assign take   = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign ctl_wr = take && wb_we_i && (wb_adr_i[7:2] == 6'h02);

    always_ff @(posedge mclk)
    begin
        pins_d <= {input_terminal_c, input_terminal_b, input_terminal_a};
    end

    // ages saturate so a long quiet run never wraps into a false pass
    always_ff @(posedge mclk)
    begin
        if (reset || ctl_wr)
            ctl_age <= 8'h00;
        else if (ctl_age != 8'hff)
            ctl_age <= ctl_age + 8'h01;
    end

    always_ff @(posedge mclk)
    begin
        if (reset || ctl_wr || ({input_terminal_c, input_terminal_b,
            input_terminal_a} != pins_d))
            pin_age <= 8'h00;
        else if (pin_age != 8'hff)
            pin_age <= pin_age + 8'h01;
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    sequence s_take;
        take;
    endsequence

    sequence s_ack_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    a_ack_answer: assert property (s_take |=> s_ack_pulse)
        else $error("bus ack missing or too long");
    a_ack_spurious: assert property (
        !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("bus ack without request");
    a_reset_quiet: assert property ($fell(reset) |->
        !wb_ack_o && output_signal_sel == 16'h0000)
        else $error("outputs not cleared by reset");
    a_default_off: assert property ($fell(reset) |->
        (!fwd_torque_limit_req && !rev_torque_limit_req) [*3])
        else $error("request active with default code");
    a_digit_range: assert property (
        (output_signal_sel & 16'hcccc) == 16'h0000)
        else $error("output select digit above three");
    a_outsel_restart: assert property (
        !$stable(output_signal_sel) |-> ctl_age <= 8'h04)
        else $error("output select changed without restart");
    a_fwd_cause: assert property (
        !$stable(fwd_torque_limit_req) |-> pin_age <= 8'h07)
        else $error("forward request changed without cause");
    a_rev_cause: assert property (
        !$stable(rev_torque_limit_req) |-> pin_age <= 8'h07)
        else $error("reverse request changed without cause");

endmodule : tlim_mapper_checker

bind tlim_mapper tlim_mapper_checker u_chk
(
    .mclk                 (mclk),
    .reset                (reset),
    .wb_cyc_i             (wb_cyc_i),
    .wb_stb_i             (wb_stb_i),
    .wb_we_i              (wb_we_i),
    .wb_adr_i             (wb_adr_i),
    .wb_ack_o             (wb_ack_o),
    .input_terminal_a     (input_terminal_a),
    .input_terminal_b     (input_terminal_b),
    .input_terminal_c     (input_terminal_c),
    .fwd_torque_limit_req (fwd_torque_limit_req),
    .rev_torque_limit_req (rev_torque_limit_req),
    .output_signal_sel    (output_signal_sel)
);

`default_nettype wire

// >>> tb/tlim_mapper_tb_top.sv
/*
 * Self-checking bench for the torque-limit input mapper.
 * Assumes the checker is bound and the host model drives pins.
 */
`default_nettype none

module tlim_mapper_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import tlim_pkg::*;

    // ****************************************************************
    // signals
    // ****************************************************************
    logic         mclk;
    logic         reset;
    logic         cyc;
    logic         stb;
    logic         we;
    tlim_adr_t    adr;
    tlim_sel_t    sel;
    tlim_word_t   dat_w;
    tlim_word_t   dat_r;
    logic         ack;
    logic         ta;
    logic         tb;
    logic         tc;
    logic         fwd;
    logic         rev;
    tlim_outsel_t osel;
    logic         pend;
    logic [2:0]   lvl;
    tlim_word_t   q;
    tlim_word_t   w;
    tlim_code_t   r;
    int           err_total;
    int           samples_checked;

    tlim_mapper uut (.mclk(mclk), .reset(reset), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
        .input_terminal_a(ta), .input_terminal_b(tb),
        .input_terminal_c(tc), .fwd_torque_limit_req(fwd),
        .rev_torque_limit_req(rev), .output_signal_sel(osel),
        .restart_pending(pend));

    tlim_host_model u_host (.mclk(mclk), .level_req(lvl),
        .input_terminal_a(ta), .input_terminal_b(tb),
        .input_terminal_c(tc));

    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : results

    task automatic check(input string name, input tlim_word_t seen,
                         input tlim_word_t exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic bus(input logic w, input tlim_adr_t a,
                       input tlim_word_t d, output tlim_word_t rd);
        @(posedge mclk);
        cyc   <= 1'b1;
        stb   <= 1'b1;
        we    <= w;
        adr   <= a;
        dat_w <= d;
        // no local limit: a missing ack is ended by the watchdog
        do
        begin
            @(posedge mclk);
        end
        while (ack !== 1'b1);
        rd = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : bus

    function automatic logic exp_req(input tlim_code_t k,
                                     input logic [2:0] p);
        case (k)
            4'h0: return !p[0];
            4'h1: return !p[1];
            4'h7: return 1'b1;
            4'h8: return 1'b0;
            4'h9: return p[0];
            4'ha: return p[1];
            default: return (k < 4'h7) ? !p[2] : p[2];
        endcase
    endfunction : exp_req

    // ****************************************************************
    // clock, watchdog, sequence
    // ****************************************************************
    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    // the run needs about 750 cycles
    initial
    begin
        #2000000;
        err_total++;
        results();
    end

    initial
    begin
        {reset, cyc, stb, we, adr, sel, dat_w} = {4'h8, 8'h00, 4'hf, 32'h0};
        lvl = 3'h7;
        err_total = 0;
        samples_checked = 0;
        void'($urandom(10698));
        repeat (5) @(posedge mclk);
        reset <= 1'b0;
        bus(1'b0, 8'h00, 32'h0, q);
        check("select", q, 32'h88);
        bus(1'b0, 8'h14, 32'h0, q);
        check("unmapped", q, 32'h0);
        $display("test reset values done");
        bus(1'b1, 8'h04, 32'h3210, q);
        repeat (2) @(posedge mclk);
        check("outsel held", {16'h0, osel}, 32'h0);
        check("pending", {31'h0, pend}, 32'h1);
        bus(1'b1, 8'h08, 32'h1, q);
        repeat (4) @(posedge mclk);
        check("outsel", {16'h0, osel}, 32'h3210);
        bus(1'b0, 8'h10, 32'h0, q);
        check("active", q, 32'h3210_0088);
        bus(1'b1, 8'h04, 32'h0400, q);
        bus(1'b0, 8'h0c, 32'h0, q);
        check("range flag", {31'h0, q[3]}, 32'h1);
        bus(1'b0, 8'h04, 32'h0, q);
        check("outsel kept", q, 32'h3210);
        bus(1'b1, 8'h0c, 32'h8, q);
        bus(1'b0, 8'h0c, 32'h0, q);
        check("range clear", {31'h0, q[3]}, 32'h0);
        $display("test output select done");
        for (int f = 0; f < 16; f++)
        begin
            r = 4'($urandom);
            bus(1'b1, 8'h00, {24'h0, r, 4'(f)}, q);
            bus(1'b1, 8'h08, 32'h1, q);
            repeat (4)
            begin
                lvl <= 3'($urandom);
                repeat (9) @(posedge mclk);
                q = {31'h0, fwd};
                w = {31'h0, exp_req(4'(f), lvl)};
                if (f < 7)
                    check("fwd", q, w);
                else
                    check("fwd", q, w);
                check("rev", {31'h0, rev}, {31'h0, exp_req(r, lvl)});
            end
        end
        $display("test code table done");
        reset <= 1'b1;
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        repeat (2) @(posedge mclk);
        check("outsel after reset", {16'h0, osel}, 32'h0);
        check("fwd after reset", {31'h0, fwd}, 32'h0);
        $display("test second reset done");
        results();
    end

endmodule : tlim_mapper_tb_top

`default_nettype wire

// >>> verilog/tlim_decode.sv
/*
 * One selector decoder: turns a four-bit code and the filtered
 * terminal levels into one request.
 * Assumes levels are already synchronised; purely combinational.
 */
`default_nettype none
`include "tlim_defines.svh"

module tlim_decode
(
    // selector and terminals
    input  wire tlim_pkg::tlim_code_t code,
    input  wire tlim_pkg::tlim_term_t term_level,
    // result
    output tlim_pkg::tlim_src_t       src,
    output logic                      req
);
    import tlim_pkg::*;

    logic active_level;

    always_comb
    begin
        src          = TLIM_SRC_C;
        active_level = 1'b1;
        if (code == `TLIM_CODE_A_ON)
        begin
            src          = TLIM_SRC_A;
            active_level = 1'b0;
        end
        else if (code == `TLIM_CODE_B_ON)
        begin
            src          = TLIM_SRC_B;
            active_level = 1'b0;
        end
        else if (code <= `TLIM_CODE_C_ON_HI)
        begin
            src          = TLIM_SRC_C;
            active_level = 1'b0;
        end
        else if (code == `TLIM_CODE_FORCE_ON)
            src = TLIM_SRC_ON;
        else if (code == `TLIM_CODE_FORCE_OFF)
            src = TLIM_SRC_OFF;
        else if (code == `TLIM_CODE_A_OFF)
            src = TLIM_SRC_A;
        else if (code == `TLIM_CODE_B_OFF)
            src = TLIM_SRC_B;
        else
            src = TLIM_SRC_C;
    end

    always_comb
    begin
        case (src)
            TLIM_SRC_A:   req = (term_level[0] == active_level);
            TLIM_SRC_B:   req = (term_level[1] == active_level);
            TLIM_SRC_C:   req = (term_level[2] == active_level);
            TLIM_SRC_ON:  req = 1'b1;
            TLIM_SRC_OFF: req = 1'b0;
            default:      req = 1'b0;
        endcase
    end

endmodule : tlim_decode

`default_nettype wire

// >>> verilog/tlim_mapper.sv
/*
 * Torque-limit input mapper: Wishbone register file, terminal
 * synchronisers, and forward/reverse request selection.
 * Assumes a classic Wishbone master on mclk, a synchronous
 * active-high reset, and terminals that are asynchronous pins.
 */
`default_nettype none
`include "tlim_defines.svh"

module tlim_mapper
(
    // clock and reset
    input  wire logic                   mclk,
    input  wire logic                   reset,
    // wishbone slave
    input  wire logic                   wb_cyc_i,
    input  wire logic                   wb_stb_i,
    input  wire logic                   wb_we_i,
    input  wire tlim_pkg::tlim_adr_t    wb_adr_i,
    input  wire tlim_pkg::tlim_sel_t    wb_sel_i,
    input  wire tlim_pkg::tlim_word_t   wb_dat_i,
    output tlim_pkg::tlim_word_t        wb_dat_o,
    output logic                        wb_ack_o,
    // input terminals
    input  wire logic                   input_terminal_a,
    input  wire logic                   input_terminal_b,
    input  wire logic                   input_terminal_c,
    // requests and settings
    output logic                        fwd_torque_limit_req,
    output logic                        rev_torque_limit_req,
    output tlim_pkg::tlim_outsel_t      output_signal_sel,
    output logic                        restart_pending
);
    import tlim_pkg::*;

    // ************************************************************
    // declarations
    // ************************************************************
    localparam int CHANNELS = 2;
    localparam int TERMS    = 3;

    tlim_term_t   term_raw;
    tlim_term_t   sync_1;
    tlim_term_t   sync_2;
    tlim_term_t   sync_3;
    tlim_term_t   term_level;

    tlim_code_t   pend_code [CHANNELS];
    tlim_code_t   act_code  [CHANNELS];
    logic [1:0]   dec_req;
    logic [1:0]   req;

    tlim_outsel_t pend_outsel;
    tlim_outsel_t act_outsel;
    tlim_outsel_t next_outsel;
    logic         outsel_ok;
    logic         range_err;
    logic         restart;

    logic         bus_req;
    logic         wr_fire;
    logic         rd_fire;
    tlim_adr_t    word_adr;
    tlim_word_t   rdata;
    logic         hit_select;
    logic         hit_outsel;
    logic         hit_control;
    logic         hit_status;
    logic         hit_active;

    // ************************************************************
    // terminal synchronisers
    // ************************************************************
    // three stages; a level counts only once stages two and three
    // agree, which also rejects a single-cycle glitch
    assign term_raw = {input_terminal_c, input_terminal_b,
                       input_terminal_a};

    genvar t;
    generate
        for (t = 0; t < TERMS; t = t + 1)
        begin : g_sync
            always_ff @(posedge mclk)
            begin
                if (reset)
                begin
                    sync_1[t]     <= `TLIM_PIN_IDLE;
                    sync_2[t]     <= `TLIM_PIN_IDLE;
                    sync_3[t]     <= `TLIM_PIN_IDLE;
                    term_level[t] <= `TLIM_PIN_IDLE;
                end
                else
                begin
                    sync_1[t] <= term_raw[t];
                    sync_2[t] <= sync_1[t];
                    sync_3[t] <= sync_2[t];
                    if (sync_2[t] == sync_3[t])
                        term_level[t] <= sync_3[t];
                end
            end
        end
    endgenerate

    // ************************************************************
    // bus decode
    // ************************************************************
    assign bus_req  = wb_cyc_i & wb_stb_i;
    assign wr_fire  = bus_req & wb_we_i & ~wb_ack_o;
    assign rd_fire  = bus_req & ~wb_we_i & ~wb_ack_o;
    assign word_adr = {wb_adr_i[7:2], 2'b00};

    assign hit_select  = (word_adr == `TLIM_ADR_SELECT);
    assign hit_outsel  = (word_adr == `TLIM_ADR_OUTSEL);
    assign hit_control = (word_adr == `TLIM_ADR_CONTROL);
    assign hit_status  = (word_adr == `TLIM_ADR_STATUS);
    assign hit_active  = (word_adr == `TLIM_ADR_ACTIVE);

    // one wait-free cycle: ack follows the request edge and drops
    // the cycle after, so a held strobe is acked every other cycle, never twice in a row
    always_ff @(posedge mclk)
    begin
        if (reset)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= bus_req & ~wb_ack_o;
    end

    // ************************************************************
    // pending selector codes
    // ************************************************************
    // software writes only the pending copy; the decoder never
    // sees a half-written code
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            pend_code[0] <= `TLIM_RST_CODE;
            pend_code[1] <= `TLIM_RST_CODE;
        end
        else if (wr_fire && hit_select && wb_sel_i[0])
        begin
            pend_code[0] <= wb_dat_i[`TLIM_SEL_FWD_LSB +: 4];
            pend_code[1] <= wb_dat_i[`TLIM_SEL_REV_LSB +: 4];
        end
    end

    // ************************************************************
    // output signal selection
    // ************************************************************
    always_comb
    begin
        next_outsel = pend_outsel;
        if (wb_sel_i[0])
            next_outsel[7:0] = wb_dat_i[7:0];
        if (wb_sel_i[1])
            next_outsel[15:8] = wb_dat_i[15:8];
        outsel_ok = 1'b1;
        for (int d = 0; d < 4; d = d + 1)
        begin
            if (next_outsel[d*4 +: 4] > `TLIM_DIGIT_MAX)
                outsel_ok = 1'b0;
        end
    end

    // a value with any digit above three is dropped whole
    always_ff @(posedge mclk)
    begin
        if (reset)
            pend_outsel <= `TLIM_RST_OUTSEL;
        else if (wr_fire && hit_outsel && outsel_ok)
            pend_outsel <= next_outsel;
    end

    // sticky error; a new fault beats a clear in the same cycle
    always_ff @(posedge mclk)
    begin
        if (reset)
            range_err <= 1'b0;
        else if (wr_fire && hit_outsel && !outsel_ok)
            range_err <= 1'b1;
        else if (wr_fire && hit_status && wb_sel_i[0]
                 && wb_dat_i[`TLIM_STAT_ERR])
            range_err <= 1'b0;
    end

    // ************************************************************
    // restart
    // ************************************************************
    always_ff @(posedge mclk)
    begin
        if (reset)
            restart <= 1'b0;
        else
            restart <= wr_fire & hit_control & wb_sel_i[0]
                       & wb_dat_i[`TLIM_CTRL_RESTART];
    end

    // settings change only at reset or restart, never mid-run
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            act_code[0] <= `TLIM_RST_CODE;
            act_code[1] <= `TLIM_RST_CODE;
            act_outsel  <= `TLIM_RST_OUTSEL;
        end
        else if (restart)
        begin
            act_code[0] <= pend_code[0];
            act_code[1] <= pend_code[1];
            act_outsel  <= pend_outsel;
        end
    end

    assign output_signal_sel = act_outsel;
    assign restart_pending   = (pend_code[0] != act_code[0])
                             | (pend_code[1] != act_code[1])
                             | (pend_outsel  != act_outsel);

    // ************************************************************
    // request selection
    // ************************************************************
    genvar c;
    generate
        for (c = 0; c < CHANNELS; c = c + 1)
        begin : g_chan
            tlim_decode u_decode
            (
                .code       (act_code[c]),
                .term_level (term_level),
                .src        (),
                .req        (dec_req[c])
            );

            // one register between the decoder and the pin; five from the terminal
            always_ff @(posedge mclk)
            begin
                if (reset)
                    req[c] <= 1'b0;
                else
                    req[c] <= dec_req[c];
            end
        end
    endgenerate

    assign fwd_torque_limit_req = req[0];
    assign rev_torque_limit_req = req[1];

    // ************************************************************
    // read back
    // ************************************************************
    always_comb
    begin
        rdata = 32'h0000_0000;
        if (hit_select)
        begin
            rdata[`TLIM_SEL_FWD_LSB +: 4] = pend_code[0];
            rdata[`TLIM_SEL_REV_LSB +: 4] = pend_code[1];
        end
        else if (hit_outsel)
            rdata[15:0] = pend_outsel;
        else if (hit_status)
        begin
            rdata[`TLIM_STAT_FWD]          = req[0];
            rdata[`TLIM_STAT_REV]          = req[1];
            rdata[`TLIM_STAT_PEND]         = restart_pending;
            rdata[`TLIM_STAT_ERR]          = range_err;
            rdata[`TLIM_STAT_TERM_LSB +: 3] = term_level;
        end
        else if (hit_active)
        begin
            rdata[`TLIM_ACT_FWD_LSB +: 4]  = act_code[0];
            rdata[`TLIM_ACT_REV_LSB +: 4]  = act_code[1];
            rdata[`TLIM_ACT_OUT_LSB +: 16] = act_outsel;
        end
    end

    // control and unmapped words read zero
    always_ff @(posedge mclk)
    begin
        if (reset)
            wb_dat_o <= 32'h0000_0000;
        else if (rd_fire)
            wb_dat_o <= rdata;
    end

endmodule : tlim_mapper

`default_nettype wire
